// >>> design/ebs_strobe_ctrl.sv
`timescale 1ns/1ps

module ebs_strobe_ctrl
    import ebs_pkg::*;
(
    input wire logic mclk_i, // system clock, 25 MHz
    input wire logic arst_n_i, // async reset, active low
    input wire logic req_valid_i, // access request, taken when idle
    input wire ebs_req_t req_i, // access kind and byte lanes
    input wire ebs_cfg_t cfg_i, // system configuration bits
    input wire logic ready_i, // ready pin, high means wait
    output logic load_strobe_n_o, // external load strobe
    output logic store_strobe_n_o, // external store strobe
    output logic busy_o, // access in progress
    output logic waiting_o, // wait state being inserted
    output logic done_o // access completed, one cycle
);

    ebs_state_t state_r, state_nxt;
    ebs_req_t req_r, req_nxt;
    ebs_cfg_t cfg_r, cfg_nxt;
    logic load_n_r, load_n_nxt;
    logic store_n_r, store_n_nxt;
    logic busy_r, busy_nxt;
    logic wait_r, wait_nxt;
    logic done_r, done_nxt;

    // request and configuration are frozen for the whole access so a
    // mid-access change of the mode bit cannot glitch the strobe
    always_comb
    begin
        state_nxt = state_r;
        req_nxt = req_r;
        cfg_nxt = cfg_r;
        load_n_nxt = load_n_r;
        store_n_nxt = store_n_r;
        busy_nxt = busy_r;
        wait_nxt = wait_r;
        done_nxt = EBS_FLAG_CLR;
        unique case (state_r)
            EBS_ST_IDLE:
            begin
                load_n_nxt = EBS_STROBE_OFF;
                store_n_nxt = EBS_STROBE_OFF;
                if (req_valid_i)
                begin
                    state_nxt = EBS_ST_ACCESS;
                    req_nxt = req_i;
                    cfg_nxt = cfg_i;
                    busy_nxt = EBS_FLAG_SET;
                    load_n_nxt = ebs_is_read_f(req_i) ? EBS_STROBE_ON : EBS_STROBE_OFF;
                    store_n_nxt = ebs_store_f(cfg_i, req_i) ? EBS_STROBE_ON : EBS_STROBE_OFF;
                end
            end
            EBS_ST_ACCESS:
            begin
                // ready only counts when the function is enabled
                if (cfg_r.ready_en && ready_i)
                begin
                    wait_nxt = EBS_FLAG_SET;
                end
                else
                begin
                    state_nxt = EBS_ST_IDLE;
                    load_n_nxt = EBS_STROBE_OFF;
                    store_n_nxt = EBS_STROBE_OFF;
                    busy_nxt = EBS_FLAG_CLR;
                    wait_nxt = EBS_FLAG_CLR;
                    done_nxt = EBS_FLAG_SET;
                end
            end
            default:
            begin
                state_nxt = EBS_ST_IDLE;
                load_n_nxt = EBS_STROBE_OFF;
                store_n_nxt = EBS_STROBE_OFF;
                busy_nxt = EBS_FLAG_CLR;
                wait_nxt = EBS_FLAG_CLR;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_r <= EBS_ST_IDLE;
            req_r <= EBS_REQ_RST;
            cfg_r <= EBS_CFG_RST;
            load_n_r <= EBS_STROBE_OFF;
            store_n_r <= EBS_STROBE_OFF;
            busy_r <= EBS_FLAG_CLR;
            wait_r <= EBS_FLAG_CLR;
            done_r <= EBS_FLAG_CLR;
        end
        else
        begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            cfg_r <= cfg_nxt;
            load_n_r <= load_n_nxt;
            store_n_r <= store_n_nxt;
            busy_r <= busy_nxt;
            wait_r <= wait_nxt;
            done_r <= done_nxt;
        end
    end

    assign load_strobe_n_o = load_n_r;
    assign store_strobe_n_o = store_n_r;
    assign busy_o = busy_r;
    assign waiting_o = wait_r;
    assign done_o = done_r;

    sequence accept_s;
        (state_r == EBS_ST_IDLE) && req_valid_i;
    endsequence

    sequence store_accept_s;
        accept_s ##0 (req_i.kind == EBS_STORE);
    endsequence

    sequence hold_wait_s;
        busy_o && cfg_r.ready_en && ready_i;
    endsequence

    load_on_read_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        accept_s ##0 ebs_is_read_f(req_i) |=> !load_strobe_n_o && store_strobe_n_o)
        else $error("load strobe missing on read access");

    no_load_store_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        store_accept_s |=> load_strobe_n_o throughout (busy_o [*1]))
        else $error("load strobe active during store");

    combined_store_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        store_accept_s ##0 (cfg_i.strobe_mode_select == EBS_MODE_COMBINED) |=> !store_strobe_n_o)
        else $error("store strobe missing in combined mode");

    low_byte_wide_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        store_accept_s ##0 (cfg_i.strobe_mode_select == EBS_MODE_LOW_BYTE) && cfg_i.bus_16bit
        |=> store_strobe_n_o == !$past(req_i.lo_byte))
        else $error("store strobe wrong for low-byte mode on wide bus");

    low_byte_narrow_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        store_accept_s ##0 (cfg_i.strobe_mode_select == EBS_MODE_LOW_BYTE) && !cfg_i.bus_16bit
        |=> !store_strobe_n_o)
        else $error("store strobe missing for low-byte mode on narrow bus");

    mode_bit_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        store_accept_s ##0 cfg_i.bus_16bit && !req_i.lo_byte
        |=> store_strobe_n_o == $past(cfg_i.strobe_mode_select))
        else $error("mode bit does not select the store strobe behaviour");

    ready_ignored_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        accept_s ##0 !cfg_i.ready_en |=> busy_o ##1 (done_o && !busy_o))
        else $error("access stretched while ready function disabled");

    ready_wait_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        hold_wait_s |=> busy_o && waiting_o && !done_o)
        else $error("access ended while ready held high");

    ready_release_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        busy_o && waiting_o && !ready_i |=> done_o && !busy_o && load_strobe_n_o && store_strobe_n_o)
        else $error("access not ended after ready returned low");

    idle_strobes_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !busy_o |-> load_strobe_n_o && store_strobe_n_o)
        else $error("strobe active outside an access");

    // hold checks cover every cycle of a stretched access, not only its first
    sequence store_held_s;
        busy_o && (req_r.kind == EBS_STORE);
    endsequence

    load_level_hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        busy_o |-> load_strobe_n_o == !ebs_is_read_f(req_r))
        else $error("load strobe level wrong during access");

    read_no_store_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        busy_o && ebs_is_read_f(req_r) |-> store_strobe_n_o)
        else $error("store strobe active during read access");

    combined_hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        store_held_s ##0 (cfg_r.strobe_mode_select == EBS_MODE_COMBINED) |-> !store_strobe_n_o)
        else $error("store strobe dropped in combined mode");

    wide_hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        store_held_s ##0 (cfg_r.strobe_mode_select == EBS_MODE_LOW_BYTE) && cfg_r.bus_16bit
        |-> store_strobe_n_o == !req_r.lo_byte)
        else $error("store strobe wrong during low-byte access on wide bus");

    narrow_hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        store_held_s ##0 (cfg_r.strobe_mode_select == EBS_MODE_LOW_BYTE) && !cfg_r.bus_16bit
        |-> !store_strobe_n_o)
        else $error("store strobe dropped on narrow bus");

    mode_capture_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        accept_s |=> cfg_r == $past(cfg_i))
        else $error("configuration bits not captured at acceptance");

    mode_frozen_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        busy_o && $past(busy_o) |-> $stable(cfg_r) && $stable(req_r))
        else $error("configuration changed during access");

    strobes_steady_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        busy_o && $past(busy_o) |-> $stable(load_strobe_n_o) && $stable(store_strobe_n_o))
        else $error("strobe changed in the middle of an access");

    no_ready_wait_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !cfg_r.ready_en |-> !waiting_o)
        else $error("wait state inserted while ready function disabled");

    ready_off_end_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        busy_o && !cfg_r.ready_en |=> done_o && !busy_o)
        else $error("access not ended with ready function disabled");

    idle_no_wait_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !busy_o |-> !waiting_o)
        else $error("wait flag set outside an access");

    done_single_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        done_o |=> !done_o)
        else $error("completion pulse longer than one cycle");

    busy_refuse_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        busy_o && req_valid_i |=> $stable(req_r))
        else $error("request taken while access in progress");

endmodule : ebs_strobe_ctrl

// >>> design/ebs_pkg.sv
package ebs_pkg;

    // access kinds presented by the core side
    typedef enum logic [1:0] {
        EBS_FETCH = 2'b00,
        EBS_LOAD = 2'b01,
        EBS_STORE = 2'b10
    } ebs_kind_t;

    typedef enum logic [1:0] {
        EBS_ST_IDLE = 2'b00,
        EBS_ST_ACCESS = 2'b01
    } ebs_state_t;

    // one external access request
    typedef struct packed {
        ebs_kind_t kind;
        logic lo_byte;
        logic hi_byte;
    } ebs_req_t;

    // bits taken from the system configuration register
    typedef struct packed {
        logic strobe_mode_select;
        logic bus_16bit;
        logic ready_en;
    } ebs_cfg_t;

    localparam logic EBS_MODE_COMBINED = 1'b0;
    localparam logic EBS_MODE_LOW_BYTE = 1'b1;
    localparam logic EBS_STROBE_ON = 1'b0;
    localparam logic EBS_STROBE_OFF = 1'b1;
    localparam logic EBS_FLAG_CLR = 1'b0;
    localparam logic EBS_FLAG_SET = 1'b1;

    localparam ebs_req_t EBS_REQ_RST = '{kind: EBS_FETCH, lo_byte: 1'b0, hi_byte: 1'b0};
    localparam ebs_cfg_t EBS_CFG_RST = '{strobe_mode_select: EBS_MODE_COMBINED, bus_16bit: 1'b0, ready_en: 1'b0};

    function automatic logic ebs_is_read_f(input ebs_req_t req);
        ebs_is_read_f = (req.kind == EBS_FETCH) || (req.kind == EBS_LOAD);
    endfunction : ebs_is_read_f

    // store strobe wanted for this request under this configuration
    function automatic logic ebs_store_f(input ebs_cfg_t cfg, input ebs_req_t req);
        logic st;
        st = (req.kind == EBS_STORE);
        if (cfg.strobe_mode_select == EBS_MODE_LOW_BYTE && cfg.bus_16bit)
        begin
            st = st && req.lo_byte;
        end
        ebs_store_f = st;
    endfunction : ebs_store_f

endpackage : ebs_pkg

// >>> tb/ebs_ready_model.sv
`timescale 1ns/1ps

module ebs_ready_model (
    input wire logic mclk_i, // bus clock
    input wire logic arst_n_i, // reset, active low
    input wire logic busy_i, // access under way
    input wire logic [1:0] nwait_i, // wait states for next access
    output logic ready_o // ready pin, high means wait
);
    logic [1:0] cnt_r;

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cnt_r <= 2'h0;
        else if (!busy_i)
            cnt_r <= nwait_i;
        else if (cnt_r != 2'h0)
            cnt_r <= cnt_r - 2'h1;
    end

    // pull-up holds the pin high between accesses
    assign ready_o = busy_i ? (cnt_r != 2'h0) : 1'b1;
endmodule : ebs_ready_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import ebs_pkg::*;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic req_valid_i = 1'b0;
    ebs_req_t req_i = EBS_REQ_RST;
    ebs_cfg_t cfg_i = EBS_CFG_RST;
    logic ready_i;
    logic load_n, store_n, busy, waiting, done;
    logic [1:0] nwait = 2'h0;
    int fail_count = 0;
    int samples_checked = 0;
    int seed = 32'h903d_b090;

    always #20 mclk_i = ~mclk_i;

    ebs_strobe_ctrl dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .cfg_i(cfg_i), .ready_i(ready_i), .load_strobe_n_o(load_n), .store_strobe_n_o(store_n),
        .busy_o(busy), .waiting_o(waiting), .done_o(done));

    ebs_ready_model ready_pin (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .busy_i(busy), .nwait_i(nwait),
        .ready_o(ready_i));

    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    // active-low store strobe level expected during the access
    function automatic logic exp_store_n(input ebs_cfg_t c, input ebs_req_t r);
        return !(r.kind == EBS_STORE && !(c.strobe_mode_select && c.bus_16bit && !r.lo_byte));
    endfunction : exp_store_n

    task automatic access(input ebs_req_t r, input ebs_cfg_t c, input logic [1:0] n);
        int cyc;
        int exp_cyc;
        exp_cyc = c.ready_en ? 2 + n : 2;
        @(posedge mclk_i);
        req_valid_i <= 1'b1;
        req_i <= r;
        cfg_i <= c;
        nwait <= n;
        @(posedge mclk_i);
        req_valid_i <= 1'b0;
        #1;
        check("load_strobe", {3'h0, !(r.kind == EBS_FETCH || r.kind == EBS_LOAD)}, {3'h0, load_n});
        check("store_strobe", {3'h0, exp_store_n(c, r)}, {3'h0, store_n});
        check("busy_start", 4'h2, {2'h0, busy, waiting});
        cyc = 1;
        while (done !== 1'b1 && cyc < 12)
        begin
            @(posedge mclk_i);
            #1;
            cyc++;
            if (done !== 1'b1)
                check("wait_state", {3'h0, c.ready_en}, {3'h0, waiting});
        end
        check("access_cycles", exp_cyc[3:0], cyc[3:0]);
        check("idle_strobes", 4'h3, {busy, waiting, load_n, store_n});
    endtask : access

    initial
    begin
        #(40 * 8000);
        fail_count++;
        close_out();
    end

    initial
    begin
        logic [31:0] tmp;
        ebs_req_t r;
        ebs_cfg_t c;
        repeat (4) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        #1;
        check("reset_state", 4'hc, {load_n, store_n, busy, done});
        $display("reset test done");
        for (int i = 0; i < 300; i++)
        begin
            tmp = $random(seed);
            // first eight: low-byte-clear stores under every configuration
            r.kind = (i < 8) ? EBS_STORE : ebs_kind_t'(tmp[1:0]);
            r.lo_byte = (i < 8) ? 1'b0 : tmp[2];
            r.hi_byte = tmp[3];
            c = (i < 8) ? ebs_cfg_t'(i[2:0]) : ebs_cfg_t'(tmp[6:4]);
            access(r, c, tmp[9:8]);
        end
        $display("access test done");
        // reset pulled in the middle of a stretched store, after a refused request
        r = '{kind: EBS_STORE, lo_byte: 1'b0, hi_byte: 1'b1};
        c = '{strobe_mode_select: EBS_MODE_COMBINED, bus_16bit: 1'b1, ready_en: 1'b1};
        @(posedge mclk_i);
        req_valid_i <= 1'b1;
        req_i <= r;
        cfg_i <= c;
        nwait <= 2'h3;
        @(posedge mclk_i);
        req_i <= '{kind: EBS_LOAD, lo_byte: 1'b0, hi_byte: 1'b0};
        @(posedge mclk_i);
        req_valid_i <= 1'b0;
        #1;
        check("refused_request", 4'hb, {load_n, store_n, busy, waiting});
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b0;
        #1;
        check("mid_reset", 4'hc, {load_n, store_n, busy, waiting});
        repeat (4) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        check("after_reset", 4'hc, {load_n, store_n, busy, done});
        access(r, c, 2'h1);
        $display("reset recovery test done");
        close_out();
    end
endmodule : tb_top
